// ---- rtl/codec_mixer_power_control_regs.sv ----
`timescale 1ns/1ps
module codec_mixer_power_control_regs #(
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                ARST_N,
  input  wire logic                POWER_STATE_STRAP,
  // Register access from the link frame decoder
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire logic [6:0]          REG_ADDR,
  input  wire logic [15:0]         REG_WDATA,
  output logic      [15:0]         REG_RDATA,
  output logic                     REG_RVALID,
  // Control words to the analogue section
  output logic      [15:0]         AUX_OUTPUT_CONTROL,
  output logic      [15:0]         DAC_MIXER_GAIN,
  output logic      [15:0]         RECORD_SELECTOR,
  output logic      [15:0]         RECORD_GAIN,
  output logic      [15:0]         STEREO_WIDENING_CONTROL,
  output logic                     STEREO_WIDEN_ENABLE,
  output logic                     ADC_DAC_LOOPBACK,
  // Power control
  output logic      [15:0]         BLOCK_POWER_ON,
  output logic      [6:0]          STD_POWER_DOWN,
  output logic                     LINK_POWER_DOWN,
  output logic                     INTERNAL_CLOCK_OFF,
  // Sample paths
  input  wire logic [SAMPLE_W-1:0] LINK_DAC_LEFT,
  input  wire logic [SAMPLE_W-1:0] LINK_DAC_RIGHT,
  input  wire logic                LINK_DAC_VALID,
  input  wire logic [SAMPLE_W-1:0] ADC_LEFT,
  input  wire logic [SAMPLE_W-1:0] ADC_RIGHT,
  input  wire logic                ADC_VALID,
  output logic      [SAMPLE_W-1:0] DAC_LEFT,
  output logic      [SAMPLE_W-1:0] DAC_RIGHT,
  output logic                     DAC_VALID
);

  // ==========================================================
  // Address decode
  // ==========================================================
  logic [5:0]  word_idx;
  logic [5:0]  rel_idx;
  logic        rw_hit;
  logic        pr_hit;
  logic [2:0]  sel;

  assign word_idx = REG_ADDR[6:1];
  assign rel_idx  = word_idx - codec_regs_pkg::FIRST_WORD;
  assign rw_hit   = !REG_ADDR[0] && (rel_idx < 6'(codec_regs_pkg::NUM_RW));
  assign pr_hit   = REG_ADDR == codec_regs_pkg::STANDARD_POWER_CONTROL_ADDR;
  assign sel      = rel_idx[2:0];

  // ==========================================================
  // Plain read/write registers
  // ==========================================================
  logic [15:0] regs_q [codec_regs_pkg::NUM_RW];

  genvar g;
  generate
    for (g = 0; g < codec_regs_pkg::NUM_RW; g++)
    begin : g_reg
      always_ff @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
          regs_q[g] <= codec_regs_pkg::RW_RESET[g];
        else if (REG_WR && rw_hit && sel == 3'(g))
          regs_q[g] <= REG_WDATA & codec_regs_pkg::RW_MASK[g];
      end
    end
  endgenerate

  // ==========================================================
  // Standard power-down bits and the strap
  // ==========================================================
  // The strap is sampled on the first edge after release, since an
  // asynchronous reset may only load constants.
  logic [6:0] pr_q;
  logic       strap_done_q;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      strap_done_q <= 1'b0;
    else
      strap_done_q <= 1'b1;
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      pr_q <= 7'h00;
    else if (!strap_done_q)
      pr_q <= {7{POWER_STATE_STRAP}};
    else if (REG_WR && pr_hit)
      pr_q <= REG_WDATA[14:8];
  end

  // Ready flags: reference, mixers, DACs, ADCs
  logic [3:0] ready;
  assign ready = {~pr_q[2], ~pr_q[3], ~pr_q[1], ~pr_q[0]};

  // ==========================================================
  // Read path
  // ==========================================================
  logic [15:0] rdata_d;

  always_comb
  begin
    rdata_d = 16'h0000;
    if (pr_hit)
      rdata_d = {1'b0, pr_q, 4'h0, ready};
    else if (rw_hit)
      rdata_d = regs_q[sel];
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      REG_RDATA  <= 16'h0000;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= rdata_d;
    end
  end

  // ==========================================================
  // Control outputs, straight from the register flops
  // ==========================================================
  assign AUX_OUTPUT_CONTROL      = regs_q[0];
  assign DAC_MIXER_GAIN          = regs_q[1];
  assign RECORD_SELECTOR         = regs_q[2];
  assign RECORD_GAIN             = regs_q[3];
  assign STEREO_WIDENING_CONTROL = regs_q[6];
  assign STEREO_WIDEN_ENABLE     =
    regs_q[5][codec_regs_pkg::STEREO_WIDEN_BIT];
  assign ADC_DAC_LOOPBACK        =
    regs_q[5][codec_regs_pkg::ADC_DAC_LOOPBACK_BIT];
  assign STD_POWER_DOWN          = pr_q;
  assign LINK_POWER_DOWN         = pr_q[codec_regs_pkg::LINK_PD_BIT];
  assign INTERNAL_CLOCK_OFF      = pr_q[codec_regs_pkg::INT_CLK_OFF_BIT];

  // ==========================================================
  // Combined power state
  // ==========================================================
  // Registered so the analogue enables never see decode glitches;
  // they lag the register write by one cycle.
  logic [15:0] std_map;
  logic [15:0] power_on_d;

  generate
    for (g = 0; g < 16; g++)
    begin : g_pwr
      assign std_map[g] = pr_q[codec_regs_pkg::PR_OF_XPD[g]];
    end
  endgenerate

  assign power_on_d = ~(regs_q[7] | std_map);

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      BLOCK_POWER_ON <= 16'h0000;
    else
      BLOCK_POWER_ON <= power_on_d;
  end

  // ==========================================================
  // Loopback sample path
  // ==========================================================
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      DAC_LEFT  <= '0;
      DAC_RIGHT <= '0;
      DAC_VALID <= 1'b0;
    end
    else if (ADC_DAC_LOOPBACK)
    begin
      DAC_VALID <= ADC_VALID;
      if (ADC_VALID)
      begin
        DAC_LEFT  <= ADC_LEFT;
        DAC_RIGHT <= ADC_RIGHT;
      end
    end
    else
    begin
      DAC_VALID <= LINK_DAC_VALID;
      if (LINK_DAC_VALID)
      begin
        DAC_LEFT  <= LINK_DAC_LEFT;
        DAC_RIGHT <= LINK_DAC_RIGHT;
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_wr(logic [6:0] a);
    REG_WR && REG_ADDR == a;
  endsequence

  sequence s_rd(logic [6:0] a);
    REG_RD && !REG_WR && REG_ADDR == a;
  endsequence

  property p_aux_fields;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::AUX_OUTPUT_CONTROL_ADDR) |=>
      AUX_OUTPUT_CONTROL[15] == $past(REG_WDATA[15]) &&
      AUX_OUTPUT_CONTROL[7:0] == ($past(REG_WDATA[7:0]) & 8'hbf);
  endproperty
  a_aux_fields: assert property (p_aux_fields)
    else $error("aux output mute/volume not stored");

  property p_aux_src;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::AUX_OUTPUT_CONTROL_ADDR) |=>
      AUX_OUTPUT_CONTROL[10:9] == $past(REG_WDATA[10:9]);
  endproperty
  a_aux_src: assert property (p_aux_src)
    else $error("aux source select not stored");

  property p_spk_src;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::AUX_OUTPUT_CONTROL_ADDR) |=>
      AUX_OUTPUT_CONTROL[8] == $past(REG_WDATA[8]);
  endproperty
  a_spk_src: assert property (p_spk_src)
    else $error("speaker pair source not stored");

  property p_dac_gain;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::DAC_MIXER_GAIN_ADDR) |=>
      DAC_MIXER_GAIN == ($past(REG_WDATA) & 16'hff1f);
  endproperty
  a_dac_gain: assert property (p_dac_gain)
    else $error("DAC mute or gain not stored");

  property p_rec_sel;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::RECORD_SELECTOR_ADDR) |=>
      RECORD_SELECTOR[15] == 1'b0 && RECORD_SELECTOR[7:3] == 5'h00 &&
      RECORD_SELECTOR[14:8] == $past(REG_WDATA[14:8]);
  endproperty
  a_rec_sel: assert property (p_rec_sel)
    else $error("record selector fields wrong");

  property p_rec_gain;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::RECORD_GAIN_ADDR) |=>
      RECORD_GAIN == $past(REG_WDATA);
  endproperty
  a_rec_gain: assert property (p_rec_gain)
    else $error("record gain word not stored");

  property p_gp_bits;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::GENERAL_PURPOSE_ADDR) |=>
      STEREO_WIDEN_ENABLE == $past(REG_WDATA[13]) &&
      ADC_DAC_LOOPBACK == $past(REG_WDATA[7]);
  endproperty
  a_gp_bits: assert property (p_gp_bits)
    else $error("general purpose bits not stored");

  property p_loopback;
    @(posedge CLK) disable iff (!ARST_N)
    ADC_DAC_LOOPBACK && ADC_VALID && !REG_WR |=>
      DAC_VALID && DAC_LEFT == $past(ADC_LEFT) &&
      DAC_RIGHT == $past(ADC_RIGHT);
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("loopback sample not forwarded");

  property p_widen;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::STEREO_WIDENING_CTRL_ADDR) |=>
      STEREO_WIDENING_CONTROL == {10'h000, $past(REG_WDATA[5:0])};
  endproperty
  a_widen: assert property (p_widen)
    else $error("widening control not stored");

  property p_xpd_off;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::EXTRA_POWER_DOWN_ADDR) ##1 !REG_WR |=>
      (BLOCK_POWER_ON & $past(REG_WDATA, 2)) == 16'h0000;
  endproperty
  a_xpd_off: assert property (p_xpd_off)
    else $error("extra power-down bit left block on");

  property p_power_on;
    @(posedge CLK) disable iff (!ARST_N)
    strap_done_q |=> BLOCK_POWER_ON ==
      ~($past(regs_q[7]) | $past(std_map));
  endproperty
  a_power_on: assert property (p_power_on)
    else $error("block power state mismatch");

  property p_ready;
    @(posedge CLK) disable iff (!ARST_N)
    s_rd(codec_regs_pkg::STANDARD_POWER_CONTROL_ADDR) |=>
      REG_RVALID && REG_RDATA[3:0] ==
      {~$past(pr_q[2]), ~$past(pr_q[3]), ~$past(pr_q[1]),
       ~$past(pr_q[0])} && REG_RDATA[7:4] == 4'h0;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready flags not inverse of power-down");

  sequence s_first;
    !strap_done_q;
  endsequence

  property p_strap;
    @(posedge CLK) disable iff (!ARST_N)
    s_first |=> STD_POWER_DOWN == {7{$past(POWER_STATE_STRAP)}};
  endproperty
  a_strap: assert property (p_strap)
    else $error("power-down bits ignore strap");

  property p_unmapped;
    @(posedge CLK) disable iff (!ARST_N)
    REG_RD && !rw_hit && !pr_hit |=> REG_RVALID && REG_RDATA == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_rec_boost;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::RECORD_SELECTOR_ADDR) |=>
      RECORD_SELECTOR[14] == $past(REG_WDATA[14]);
  endproperty
  a_rec_boost: assert property (p_rec_boost)
    else $error("record boost bit not stored");

  property p_phone_path;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::RECORD_SELECTOR_ADDR) |=>
      RECORD_SELECTOR[13:11] == $past(REG_WDATA[13:11]);
  endproperty
  a_phone_path: assert property (p_phone_path)
    else $error("ADC to phone path bits not stored");

  property p_rec_mute;
    @(posedge CLK) disable iff (!ARST_N)
    s_wr(codec_regs_pkg::RECORD_GAIN_ADDR) |=>
      RECORD_GAIN[15] == $past(REG_WDATA[15]);
  endproperty
  a_rec_mute: assert property (p_rec_mute)
    else $error("record input mute not stored");

  property p_std_pd;
    @(posedge CLK) disable iff (!ARST_N)
    strap_done_q && REG_WR && pr_hit |=>
      STD_POWER_DOWN == $past(REG_WDATA[14:8]);
  endproperty
  a_std_pd: assert property (p_std_pd)
    else $error("standard power-down bits not stored");

endmodule

// ---- rtl/codec_regs_pkg.sv ----
package codec_regs_pkg;

  // ==========================================================
  // Register addresses (7-bit link register index)
  // ==========================================================
  localparam logic [6:0] AUX_OUTPUT_CONTROL_ADDR     = 7'h16;
  localparam logic [6:0] DAC_MIXER_GAIN_ADDR         = 7'h18;
  localparam logic [6:0] RECORD_SELECTOR_ADDR        = 7'h1a;
  localparam logic [6:0] RECORD_GAIN_ADDR            = 7'h1c;
  localparam logic [6:0] GENERAL_PURPOSE_ADDR        = 7'h20;
  localparam logic [6:0] STEREO_WIDENING_CTRL_ADDR   = 7'h22;
  localparam logic [6:0] EXTRA_POWER_DOWN_ADDR       = 7'h24;
  localparam logic [6:0] STANDARD_POWER_CONTROL_ADDR = 7'h26;

  // Word index of the first plain register (address / 2)
  localparam logic [5:0] FIRST_WORD = 6'h0b;
  localparam int         NUM_RW     = 8;

  // ==========================================================
  // Plain registers 16h..24h, entry 4 (1Eh) is not present
  // ==========================================================
  localparam logic [15:0] RW_RESET [NUM_RW] = '{
    16'h8000, 16'he808, 16'h3000, 16'h8000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000
  };
  localparam logic [15:0] RW_MASK [NUM_RW] = '{
    16'h87bf, 16'hff1f, 16'h7f07, 16'hffff,
    16'h0000, 16'h2080, 16'h003f, 16'hffff
  };

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int OUTPUT_MUTE_BIT       = 15;
  localparam int AUX_SRC_LSB           = 9;
  localparam int SPK_PAIR_SRC_BIT      = 8;
  localparam int ADC_DAC_LOOPBACK_BIT  = 7;
  localparam int STEREO_WIDEN_BIT      = 13;
  localparam int PR_LSB                = 8;
  localparam int PR_WIDTH              = 7;
  localparam int LINK_PD_BIT           = 4;
  localparam int INT_CLK_OFF_BIT       = 5;

  // Standard power-down index that also gates each extra bit
  localparam int PR_OF_XPD [16] = '{
    0, 0, 0, 2, 6, 6, 2, 2, 2, 2, 3, 0, 0, 1, 1, 5
  };

endpackage

// ---- bench/link_ctrl_model.sv ----
`timescale 1ns/1ps
// ====
// Controller end of the register link, one request per call
module link_ctrl_model (
  // Clock
  input  wire logic        CLK,
  // Requests into the register bank
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [6:0]       reg_addr,
  output logic [15:0]      reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
  end

  // Strobe lasts one rising edge; released lines carry the inverse so
  // a bank that latches late sees garbage instead of a lucky match
  task automatic access(input logic wr, input logic [6:0] a,
                        input logic [15:0] d);
    @(negedge CLK);
    reg_wr = wr;
    reg_rd = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge CLK);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        CLK, ARST_N, strap, reg_wr, reg_rd, rvalid;
  logic [6:0]  reg_addr, spd;
  logic [15:0] reg_wdata, rdata, aux, dmg, rsel, rgain, widen, bpo;
  logic        wen, lb, lpd, ico, ldv, adv, dval;
  logic [15:0] ldl, ldr, adl, adr, dl, dr;
  logic [15:0] rd_q[$];
  logic [31:0] smp_q[$];
  logic [15:0] shadow[9];
  int          bad_count, num_checks;
  // Index is (address - 16h) / 2; entry 4 is the unmapped 1Eh
  localparam logic [15:0] RST[9] = '{16'h8000, 16'he808, 16'h3000,
    16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] MSK[9] = '{16'h87bf, 16'hff1f, 16'h7f07,
    16'hffff, 16'h0000, 16'h2080, 16'h003f, 16'hffff, 16'h7f00};
  localparam int PMAP[16] = '{0, 0, 0, 2, 6, 6, 2, 2, 2, 2, 3, 0, 0,
    1, 1, 5};

  // ====
  // Design and controller model
  codec_mixer_power_control_regs codec_mixer_power_control_regs_inst (
    .CLK(CLK), .ARST_N(ARST_N), .POWER_STATE_STRAP(strap),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .AUX_OUTPUT_CONTROL(aux), .DAC_MIXER_GAIN(dmg),
    .RECORD_SELECTOR(rsel), .RECORD_GAIN(rgain),
    .STEREO_WIDENING_CONTROL(widen), .STEREO_WIDEN_ENABLE(wen),
    .ADC_DAC_LOOPBACK(lb), .BLOCK_POWER_ON(bpo), .STD_POWER_DOWN(spd),
    .LINK_POWER_DOWN(lpd), .INTERNAL_CLOCK_OFF(ico),
    .LINK_DAC_LEFT(ldl), .LINK_DAC_RIGHT(ldr), .LINK_DAC_VALID(ldv),
    .ADC_LEFT(adl), .ADC_RIGHT(adr), .ADC_VALID(adv),
    .DAC_LEFT(dl), .DAC_RIGHT(dr), .DAC_VALID(dval));
  link_ctrl_model link_ctrl_model_inst (
    .CLK(CLK), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  // ====
  // Shared tasks
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  function automatic logic [15:0] exp_read(input int i);
    logic [6:0] p;
    p = shadow[8][14:8];
    if (i == 8)
      return {1'b0, p, 4'h0, ~p[2], ~p[3], ~p[1], ~p[0]};
    return shadow[i];
  endfunction

  function automatic logic [15:0] exp_bpo();
    logic [15:0] v;
    for (int b = 0; b < 16; b++)
      v[b] = ~(shadow[7][b] | shadow[8][8 + PMAP[b]]);
    return v;
  endfunction

  task automatic rd_at(input logic [6:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    link_ctrl_model_inst.access(1'b0, a, 16'($urandom()));
  endtask

  task automatic wr(input int i, input logic [15:0] d);
    shadow[i] = d & MSK[i];
    link_ctrl_model_inst.access(1'b1, 7'(8'h16 + 2 * i), d);
  endtask

  task automatic outs();
    repeat (3) @(negedge CLK);
    check("aux", aux, shadow[0]);
    check("dac gain", dmg, shadow[1]);
    check("rec sel", rsel, shadow[2]);
    check("rec gain", rgain, shadow[3]);
    check("widen", widen, shadow[6]);
    check("widen en", wen, shadow[5][13]);
    check("loopback", lb, shadow[5][7]);
    check("std pd", spd, shadow[8][14:8]);
    check("link pd", lpd, shadow[8][12]);
    check("clk off", ico, shadow[8][13]);
    check("power on", bpo, exp_bpo());
  endtask

  task automatic samples(input logic lbv);
    wr(5, lbv ? 16'h0080 : 16'h0000);
    repeat (2) @(negedge CLK);
    {ldl, ldr, adl, adr} = {$urandom(), $urandom()};
    ldv = 1'b1;
    adv = 1'b1;
    smp_q.push_back(lbv ? {adl, adr} : {ldl, ldr});
    @(negedge CLK);
    ldv = lbv;
    adv = ~lbv;
    @(negedge CLK);
    ldv = 1'b0;
    adv = 1'b0;
    repeat (2) @(negedge CLK);
  endtask

  task conclude();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ====
  // Result monitors: oldest note first
  always @(posedge CLK)
  begin
    #1;
    if (rvalid === 1'b1)
      check("read data", rdata, rd_q.size() ? rd_q.pop_front() : 'x);
    if (dval === 1'b1)
      check("dac data", {dl, dr}, smp_q.size() ? smp_q.pop_front() : 'x);
  end

  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  initial
  begin
    #1_000_000;
    bad_count++;
    conclude();
  end

  // ====
  // Main sequence
  initial
  begin
    void'($urandom(32'h2218c619));
    {ldv, adv, ldl, ldr, adl, adr} = '0;
    strap = 1'($urandom());
    ARST_N = 1'b0;
    repeat (20) @(negedge CLK);
    ARST_N = 1'b1;
    shadow = RST;
    shadow[8] = {1'b0, {7{strap}}, 8'h00};
    repeat (2) @(negedge CLK);
    outs();
    for (int i = 0; i < 9; i++)
      rd_at(7'(8'h16 + 2 * i), exp_read(i));
    rd_at(7'h17, 16'h0000);
    rd_at(7'h30, 16'h0000);
    repeat (4)
    begin
      for (int i = 0; i < 9; i++)
        wr(i, 16'($urandom()));
      wr(8, 16'($urandom()));
      outs();
      for (int i = 0; i < 9; i++)
        rd_at(7'(8'h16 + 2 * i), exp_read(i));
    end
    wr(7, 16'h0000);
    wr(8, 16'h0000);
    outs();
    // Second reset with the other strap level
    strap = ~strap;
    ARST_N = 1'b0;
    repeat (2) @(negedge CLK);
    ARST_N = 1'b1;
    shadow = RST;
    shadow[8] = {1'b0, {7{strap}}, 8'h00};
    outs();
    rd_at(7'h26, exp_read(8));
    samples(1'b0);
    samples(1'b1);
    repeat (3) @(negedge CLK);
    check("reads left", rd_q.size(), 0);
    check("samples left", smp_q.size(), 0);
    conclude();
  end
endmodule
